// ==== design/pulse_ctrl_defines.svh ====
// Constants for the RF pulse modulation control block.
// Assumes a 250 MHz system clock and the plain register port below.
`ifndef PULSE_CTRL_DEFINES_SVH
`define PULSE_CTRL_DEFINES_SVH

// ============================================================
// Register port widths
`define ADDR_W 5
`define DATA_W 32

// ============================================================
// Set registers, written by software
`define OFF_DUTY 5'h00
`define OFF_RATE 5'h01
`define OFF_RATE_RSVD 5'h02
`define OFF_SRC_SEL 5'h03
`define OFF_EXT_TRIG 5'h04
`define OFF_AMP_TRIG 5'h05
`define OFF_CHANNEL 5'h06
// Read-only registers
`define OFF_ACK 5'h07
`define OFF_STATUS 5'h08
// Query block, in reply order
`define QRY_CHAN 5'h10
`define QRY_RATE 5'h11
`define QRY_CORR 5'h12
`define QRY_MODE 5'h13
`define QRY_RSV0 5'h14
`define QRY_RSV1 5'h15
`define QRY_RSV2 5'h16
`define QRY_RSV3 5'h17
`define QRY_DELAY 5'h18
`define QRY_DUTY 5'h19

// ============================================================
// Field positions
`define ACK_OK_BIT 0
`define ACK_CMD_LSB 8
`define ACK_CHAN_LSB 16
`define ST_GATE_BIT 0
`define ST_BUSY_BIT 1
`define ST_CONT_BIT 2
`define ST_TRIG_BIT 3

// ============================================================
// Reset values and fixed figures
`define DUTY_FULL 7'h64
`define PCT_DIV 32'h0000_0064
`define RATE_RST 32'h0000_03E8
`define RATE_MAX_HZ 32'h0000_4D58
`define CLK_HZ 32'h0EE6_B280
`define TRIG_FREE 32'h0000_0001
`define TRIG_EXT 32'h0000_0000
`define RSVD_VAL 32'h0000_00FF
`define CORR_VAL 32'h0000_0000
`define DELAY_VAL 32'h0000_0000
`define SRC_EXT 1'h1
`define DIV_STEPS 6'h20

`endif

// ==== design/pulse_pkg.sv ====
// Types shared by the pulse modulation control and its divider.
// Assumes the constants header sits beside it.
`include "pulse_ctrl_defines.svh"

package pulse_pkg;

    // ============================================================
    // Register port request
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [1:0] {CALC_IDLE, CALC_PERIOD, CALC_ON} calc_state_t;

    // ============================================================
    // Whole state of the control block
    typedef struct packed {
        logic [6:0] duty;
        logic [31:0] rate;
        logic [31:0] rate_rsvd;
        logic src_ext;
        logic ext_trig_en;
        logic amp_trig_en;
        logic [7:0] channel;
        logic [31:0] ack;
        logic ack_pulse;
        logic dirty;
        calc_state_t calc;
        logic div_start;
        logic [31:0] div_num;
        logic [31:0] div_den;
        logic [31:0] per_tmp;
        logic [31:0] pend_period;
        logic [31:0] pend_on;
        logic pend_cont;
        logic [31:0] act_period;
        logic [31:0] act_on;
        logic act_cont;
        logic [31:0] cnt;
        logic [2:0] sync;
        logic trig_lvl;
        logic rf_gate;
        logic meas_window;
        logic meas_start;
        logic [31:0] rdata;
    } ctrl_state_t;

    // Whole state of the divider
    typedef struct packed {
        logic [31:0] rem;
        logic [31:0] quot;
        logic [31:0] den;
        logic [5:0] step;
        logic busy;
        logic done;
    } div_state_t;

endpackage

// ==== design/pulse_divider.sv ====
// Serial restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse and den is never zero.
`timescale 1ns/10ps
`default_nettype none

module pulse_divider
    import pulse_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Request
    input wire logic start,
    input wire logic [31:0] num,
    input wire logic [31:0] den,
    // Answer
    output logic done,
    output logic [31:0] quot
);

    div_state_t s_reg;
    div_state_t s_next;
    logic [32:0] trial;

    // ============================================================
    // One shift-subtract step per cycle; 32 cycles per quotient
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        trial = {s_reg.rem, s_reg.quot[31]} - {1'b0, s_reg.den};
        if (start)
        begin
            s_next.rem = '0;
            s_next.quot = num;
            s_next.den = den;
            s_next.step = `DIV_STEPS;
            s_next.busy = 1'b1;
        end
        else if (s_reg.busy)
        begin
            if (!trial[32])
            begin
                s_next.rem = trial[31:0];
                s_next.quot = {s_reg.quot[30:0], 1'b1};
            end
            else
            begin
                s_next.rem = {s_reg.rem[30:0], s_reg.quot[31]};
                s_next.quot = {s_reg.quot[30:0], 1'b0};
            end
            s_next.step = s_reg.step - 6'h01;
            if (s_reg.step == 6'h01)
            begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign done = s_reg.done;
    assign quot = s_reg.quot;

endmodule
`default_nettype wire

// ==== design/rf_pulse_modulation_control.sv ====
// Pulse modulation control of the RF source: free-running or triggered
// gating, power sampling window, and the register set software uses.
// Assumes one 250 MHz clock and a host that keeps rate and duty legal.
`timescale 1ns/10ps
`default_nettype none

module rf_pulse_modulation_control
    import pulse_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire reg_req_t bus_req,
    output logic [31:0] rdata,
    // Trigger pin
    input wire logic pulse_trigger_input,
    // RF path control
    output logic rf_gate,
    output logic src_ext_sel,
    // Power measurement timing
    output logic meas_window,
    output logic meas_start,
    // Command acknowledge
    output logic ack_pulse
);

    ctrl_state_t s_reg;
    ctrl_state_t s_next;
    logic div_done;
    logic [31:0] div_quot;
    logic pwm_on;
    logic gate_src;
    logic win_n;
    logic set_hit;

    // ============================================================
    // Shared divider for period and ON-time computation
    pulse_divider u_div (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(s_reg.div_start),
        .num(s_reg.div_num),
        .den(s_reg.div_den),
        .done(div_done),
        .quot(div_quot)
    );

    // ============================================================
    // Next-state logic
    always_comb
    begin
        s_next = s_reg;
        s_next.ack_pulse = 1'b0;
        s_next.div_start = 1'b0;
        s_next.rdata = '0;
        set_hit = 1'b0;

        // Register writes; values other than duty are stored unchecked, cut to the width of their field
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                `OFF_DUTY:
                begin
                    // Above full scale is taken as full scale
                    s_next.duty = (bus_req.wdata > `PCT_DIV) ? `DUTY_FULL
                                                             : bus_req.wdata[6:0];
                    set_hit = 1'b1;
                end
                `OFF_RATE:
                begin
                    s_next.rate = bus_req.wdata;
                    set_hit = 1'b1;
                end
                `OFF_RATE_RSVD:
                begin
                    s_next.rate_rsvd = bus_req.wdata;
                    set_hit = 1'b1;
                end
                `OFF_SRC_SEL:
                begin
                    s_next.src_ext = bus_req.wdata[0];
                    set_hit = 1'b1;
                end
                `OFF_EXT_TRIG:
                begin
                    s_next.ext_trig_en = bus_req.wdata[0];
                    set_hit = 1'b1;
                end
                `OFF_AMP_TRIG:
                begin
                    s_next.amp_trig_en = bus_req.wdata[0];
                    set_hit = 1'b1;
                end
                `OFF_CHANNEL:
                begin
                    s_next.channel = bus_req.wdata[7:0];
                    set_hit = 1'b1;
                end
                default:
                    set_hit = 1'b0;
            endcase
        end

        // Acknowledge echoes command and channel with the OK flag
        if (set_hit)
        begin
            s_next.ack = '0;
            s_next.ack[`ACK_OK_BIT] = 1'b1;
            s_next.ack[`ACK_CMD_LSB +: `ADDR_W] = bus_req.addr;
            s_next.ack[`ACK_CHAN_LSB +: 8] = s_next.channel;
            s_next.ack_pulse = 1'b1;
        end

        // Register reads; data stand in the next cycle only
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `OFF_DUTY: s_next.rdata = {25'h000_0000, s_reg.duty};
                `OFF_RATE: s_next.rdata = s_reg.rate;
                `OFF_RATE_RSVD: s_next.rdata = s_reg.rate_rsvd;
                `OFF_SRC_SEL: s_next.rdata = {31'h0000_0000, s_reg.src_ext};
                `OFF_EXT_TRIG: s_next.rdata = {31'h0000_0000, s_reg.ext_trig_en};
                `OFF_AMP_TRIG: s_next.rdata = {31'h0000_0000, s_reg.amp_trig_en};
                `OFF_CHANNEL, `QRY_CHAN: s_next.rdata = {24'h00_0000, s_reg.channel};
                `OFF_ACK: s_next.rdata = s_reg.ack;
                `OFF_STATUS:
                begin
                    s_next.rdata[`ST_GATE_BIT] = s_reg.rf_gate;
                    s_next.rdata[`ST_BUSY_BIT] = (s_reg.calc != CALC_IDLE);
                    s_next.rdata[`ST_CONT_BIT] = s_reg.act_cont;
                    s_next.rdata[`ST_TRIG_BIT] = s_reg.trig_lvl;
                end
                `QRY_RATE: s_next.rdata = s_reg.rate;
                `QRY_CORR: s_next.rdata = `CORR_VAL;
                `QRY_MODE: s_next.rdata = s_reg.ext_trig_en ? `TRIG_EXT : `TRIG_FREE;
                `QRY_RSV0, `QRY_RSV1, `QRY_RSV2, `QRY_RSV3: s_next.rdata = `RSVD_VAL;
                `QRY_DELAY: s_next.rdata = `DELAY_VAL;
                `QRY_DUTY: s_next.rdata = {25'h000_0000, s_reg.duty};
                default: s_next.rdata = '0;
            endcase
        end

        // Timing recomputation; a new duty or rate write while busy marks it dirty again
        case (s_reg.calc)
            CALC_IDLE:
            begin
                if (s_reg.dirty)
                begin
                    s_next.dirty = 1'b0;
                    if (s_reg.duty >= `DUTY_FULL)
                    begin
                        s_next.pend_cont = 1'b1;
                    end
                    else if (s_reg.rate > `RATE_MAX_HZ || s_reg.rate == '0)
                    begin
                        // Too fast for any legal pulse, or zero: run as plain carrier
                        s_next.pend_cont = 1'b1;
                    end
                    else
                    begin
                        s_next.div_num = `CLK_HZ;
                        s_next.div_den = s_reg.rate;
                        s_next.div_start = 1'b1;
                        s_next.calc = CALC_PERIOD;
                    end
                end
            end
            CALC_PERIOD:
            begin
                if (div_done)
                begin
                    s_next.per_tmp = div_quot;
                    s_next.div_num = div_quot * {25'h000_0000, s_reg.duty};
                    s_next.div_den = `PCT_DIV;
                    s_next.div_start = 1'b1;
                    s_next.calc = CALC_ON;
                end
            end
            CALC_ON:
            begin
                if (div_done)
                begin
                    // Period and ON time become visible together
                    s_next.pend_period = s_reg.per_tmp;
                    s_next.pend_on = div_quot;
                    s_next.pend_cont = 1'b0;
                    s_next.calc = CALC_IDLE;
                end
            end
            default:
                s_next.calc = CALC_IDLE;
        endcase
        // Set wins over the clear so no write is lost
        if (bus_req.wr && (bus_req.addr == `OFF_DUTY || bus_req.addr == `OFF_RATE))
            s_next.dirty = 1'b1;

        // Period counter; pending values load only at the wrap
        if (s_reg.act_cont || s_reg.cnt >= s_reg.act_period - 32'h0000_0001)
        begin
            s_next.cnt = '0;
            s_next.act_period = s_reg.pend_period;
            s_next.act_on = s_reg.pend_on;
            s_next.act_cont = s_reg.pend_cont;
        end
        else
            s_next.cnt = s_reg.cnt + 32'h0000_0001;
        pwm_on = s_reg.act_cont || (s_reg.cnt < s_reg.act_on);

        // Trigger pin: three stages, a change counts once stages two and three agree
        s_next.sync = {s_reg.sync[1:0], pulse_trigger_input};
        if (s_reg.sync[1] == s_reg.sync[2])
            s_next.trig_lvl = s_reg.sync[2];

        // RF gate: internal source only, from timer or trigger
        gate_src = s_reg.ext_trig_en ? s_reg.trig_lvl : pwm_on;
        s_next.rf_gate = (s_reg.src_ext != `SRC_EXT) && gate_src;

        // Power sampling window follows the ON part of the pulse
        if (s_reg.src_ext == `SRC_EXT)
            win_n = s_reg.amp_trig_en && s_reg.trig_lvl;
        else
            win_n = s_reg.rf_gate;
        s_next.meas_window = win_n;
        s_next.meas_start = win_n && !s_reg.meas_window;
    end

    // ============================================================
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
            s_reg.duty <= `DUTY_FULL;
            s_reg.rate <= `RATE_RST;
            s_reg.pend_cont <= 1'b1;
            s_reg.act_cont <= 1'b1;
            s_reg.calc <= CALC_IDLE;
        end
        else
            s_reg <= s_next;
    end

    // Outputs straight from the state flops
    assign rdata = s_reg.rdata;
    assign rf_gate = s_reg.rf_gate;
    assign src_ext_sel = s_reg.src_ext;
    assign meas_window = s_reg.meas_window;
    assign meas_start = s_reg.meas_start;
    assign ack_pulse = s_reg.ack_pulse;

    // ============================================================
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_duty_reset_full: assert property ($past(sys_rst) |-> s_reg.duty == `DUTY_FULL)
        else $error("duty not full after reset");
    a_full_duty_cont: assert property ((s_reg.calc == CALC_IDLE && s_reg.dirty
        && s_reg.duty == `DUTY_FULL) |=> s_reg.pend_cont)
        else $error("full duty did not select continuous output");
    a_high_rate_cont: assert property ((s_reg.calc == CALC_IDLE && s_reg.dirty
        && s_reg.rate > `RATE_MAX_HZ) |=> s_reg.pend_cont)
        else $error("excessive rate still pulsing");
    a_amp_gate_off: assert property (s_reg.src_ext |=> !s_reg.rf_gate)
        else $error("internal gate active in amplifier mode");
    a_ext_trig_gate: assert property ((!s_reg.src_ext && s_reg.ext_trig_en)
        |=> s_reg.rf_gate == $past(s_reg.trig_lvl))
        else $error("gate does not follow trigger");
    a_amp_meas_start: assert property ((s_reg.src_ext && s_reg.amp_trig_en
        && s_reg.trig_lvl && !s_reg.meas_window) |=> s_reg.meas_start ##1 !s_reg.meas_start)
        else $error("trigger edge did not start a conversion");
    a_meas_in_on: assert property (meas_start |-> meas_window && !$past(s_reg.meas_window))
        else $error("conversion started outside the ON window");
    a_rate_no_check: assert property ((bus_req.wr && bus_req.addr == `OFF_RATE)
        |=> s_reg.rate == $past(bus_req.wdata))
        else $error("rate write not stored as given");
    a_query_duty: assert property ((bus_req.rd && bus_req.addr == `QRY_DUTY)
        |=> rdata == {25'h000_0000, $past(s_reg.duty)})
        else $error("query duty field wrong");
    a_ack_echo: assert property ((bus_req.wr && bus_req.addr == `OFF_DUTY)
        |=> ack_pulse && s_reg.ack[`ACK_OK_BIT] && s_reg.ack[`ACK_CMD_LSB +: `ADDR_W] == `OFF_DUTY)
        else $error("set command not acknowledged");
    a_reload_boundary: assert property ((!s_reg.act_cont && s_reg.cnt != '0)
        |-> s_reg.act_on == $past(s_reg.act_on))
        else $error("ON time changed inside a period");

    // Register side: query fields, source switch and acknowledge echo
    a_query_mode: assert property ((bus_req.rd && bus_req.addr == `QRY_MODE
        && !s_reg.ext_trig_en) |=> rdata == `TRIG_FREE)
        else $error("free-running trigger mode not reported");
    a_delay_pct: assert property ((bus_req.rd && bus_req.addr == `QRY_DELAY)
        |=> rdata == `DELAY_VAL)
        else $error("delay field not a plain percentage");
    a_src_select: assert property ((bus_req.wr && bus_req.addr == `OFF_SRC_SEL)
        |=> src_ext_sel == $past(bus_req.wdata[0]))
        else $error("source switch does not follow the command");
    a_ack_chan: assert property ((bus_req.wr && bus_req.addr == `OFF_CHANNEL)
        |=> s_reg.ack[`ACK_CHAN_LSB +: 8] == $past(bus_req.wdata[7:0]))
        else $error("acknowledge does not echo the channel");
    a_duty_range: assert property (s_reg.duty <= `DUTY_FULL)
        else $error("stored duty above full scale");

    // Timing side: a continuous carrier and a window that trails the gate
    a_cont_gate_on: assert property ((s_reg.act_cont && !s_reg.src_ext
        && !s_reg.ext_trig_en) |=> rf_gate)
        else $error("continuous mode did not hold the gate on");
    a_window_trails: assert property (!s_reg.src_ext
        |=> meas_window == $past(s_reg.rf_gate))
        else $error("sampling window does not follow the pulse");
    a_on_in_period: assert property (!s_reg.act_cont |-> s_reg.act_on < s_reg.act_period)
        else $error("ON time not shorter than the period");

    // Scenario coverage
    c_pulsing: cover property (!s_reg.act_cont && rf_gate ##1 !rf_gate);
    c_amp_meas: cover property (s_reg.src_ext && meas_start);
    c_ext_gate: cover property (s_reg.ext_trig_en && !s_reg.src_ext && rf_gate);
    c_recompute: cover property (s_reg.calc == CALC_ON && div_done);

endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host side model: issues register cycles and notes each expected read value.
// Assumes the bench pops exp_q in the cycle after every read strobe.
`include "pulse_ctrl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module host_model
    import pulse_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output var reg_req_t bus_req
);
    logic [31:0] exp_q[$];

    // ============================================================
    // Bus cycles
    // Idle at time zero so no strobe is seen during reset
    initial bus_req = '0;

    // Released lines show inverted values, never the last ones
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: ~e, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge ref_clk);
        bus_req <= '{addr: ~a, wdata: e, wr: 1'b0, rd: 1'b0};
    endtask

    // ============================================================
    // Pulse settings
    // Reserved field always goes out as zero before the rate itself
    task automatic set_rate(input logic [31:0] r);
        wr(`OFF_RATE_RSVD, 32'h0000_0000);
        wr(`OFF_RATE, r);
    endtask
endmodule

`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the pulse modulation control.
// Assumes a 250 MHz clock and the host model driving the register port.
`include "pulse_ctrl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb
    import pulse_pkg::*;
;
    logic ref_clk;
    logic sys_rst;
    reg_req_t bus_req;
    logic [31:0] rdata;
    logic pulse_trigger_input;
    logic rf_gate;
    logic src_ext_sel;
    logic meas_window;
    logic meas_start;
    logic ack_pulse;
    logic rd_d = 1'b0;
    logic ack_d = 1'b0;
    logic gate_d = 1'b0;
    int miscompares;
    int n_tests;
    logic [31:0] lf;
    logic [31:0] qexp[10];

    // ============================================================
    // Design and host
    rf_pulse_modulation_control DUT (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus_req(bus_req),
        .rdata(rdata),
        .pulse_trigger_input(pulse_trigger_input),
        .rf_gate(rf_gate),
        .src_ext_sel(src_ext_sel),
        .meas_window(meas_window),
        .meas_start(meas_start),
        .ack_pulse(ack_pulse)
    );

    host_model host (
        .ref_clk(ref_clk),
        .bus_req(bus_req)
    );

    // Clock source
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ============================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Counts cycles the gate holds one level; bounded so a stuck gate ends it
    task automatic seg(input logic lvl, input int lim, output int n, output int ns);
        n = 0;
        ns = 0;
        while (rf_gate === lvl && n < lim)
        begin
            @(negedge ref_clk);
            n++;
            ns += int'(meas_start === 1'b1);
        end
    endtask

    // Trigger pin pulse of 12 cycles, counting conversions and gate time
    task automatic trig_pulse(output int ns, output int g);
        @(posedge ref_clk);
        pulse_trigger_input <= 1'b1;
        ns = 0;
        g = 0;
        repeat (12)
        begin
            @(negedge ref_clk);
            ns += int'(meas_start === 1'b1);
            g += int'(rf_gate === 1'b1);
        end
        @(posedge ref_clk);
        pulse_trigger_input <= 1'b0;
        repeat (10) @(negedge ref_clk);
    endtask

    // ============================================================
    // Monitor: results are judged mid-cycle, after the strobe's edge
    always @(posedge ref_clk)
    begin
        rd_d <= bus_req.rd;
        ack_d <= bus_req.wr && bus_req.addr <= `OFF_CHANNEL && !sys_rst;
    end

    always @(negedge ref_clk)
    begin
        if (rd_d && host.exp_q.size() > 0)
            chk(rdata, host.exp_q.pop_front());
        else if (!sys_rst)
            chk(rdata, 32'h0000_0000);
        if (!sys_rst)
            chk({31'h0, ack_pulse}, {31'h0, ack_d});
        // In source mode the sampling window trails the gate by one cycle
        if (!sys_rst && !src_ext_sel)
            chk({31'h0, meas_window}, {31'h0, gate_d});
        gate_d <= rf_gate;
    end

    // Watchdog sized for the longest old period plus the measured pulses
    initial
    begin
        repeat (99000) @(posedge ref_clk);
        miscompares++;
        test_done();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        int per;
        int on;
        int n;
        int s;
        logic [31:0] v;
        sys_rst = 1'b1;
        pulse_trigger_input = 1'b0;
        miscompares = 0;
        n_tests = 0;
        lf = 32'h0001_2472;
        qexp = '{32'h0, 32'h0000_03E8, 32'h0, 32'h0000_0001, 32'h0000_00FF,
                 32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF, 32'h0, 32'h0000_0064};
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Fast legal rate first, so later period boundaries come quickly
        host.set_rate(32'h0000_4D58);
        host.rd(`OFF_DUTY, 32'h0000_0064);
        host.rd(`OFF_SRC_SEL, 32'h0);
        qexp[1] = 32'h0000_4D58;
        for (int i = 0; i < 10; i++)
            host.rd(5'h10 + 5'(i), qexp[i]);
        @(negedge ref_clk);
        chk({31'h0, rf_gate}, 32'h1);
        // Random duties and rates read back as written
        for (int i = 0; i < 4; i++)
        begin
            lf = lfsr(lf);
            v = lf % 101;
            host.wr(`OFF_DUTY, v);
            host.rd(`QRY_DUTY, v);
            lf = lfsr(lf);
            v = 1000 + lf % 18801;
            host.set_rate(v);
            host.rd(`QRY_RATE, v);
        end
        // Acknowledge echoes command and channel; refused places stay quiet
        v = {24'h0, lf[15:8]};
        host.wr(`OFF_CHANNEL, v);
        host.wr(`OFF_DUTY, 32'h0000_0063);
        host.rd(`OFF_ACK, {8'h0, v[7:0], 16'h0001});
        host.rd(`QRY_CHAN, v);
        host.wr(`OFF_STATUS, 32'hFFFF_FFFF);
        host.rd(5'h1F, 32'h0);
        host.set_rate(32'h0000_4D58);
        // Pulse timing at the top rate and a duty of 99 percent
        per = `CLK_HZ / 19800;
        on = per * 99 / 100;
        // Let both divisions finish so the next wrap loads the new pair
        repeat (300) @(posedge ref_clk);
        @(negedge ref_clk);
        seg(1'b1, 30000, n, s);
        seg(1'b0, 20000, n, s);
        seg(1'b1, 20000, n, s);
        seg(1'b0, 20000, n, s);
        chk(n, per - on);
        seg(1'b1, 20000, n, s);
        chk(n, on);
        chk(s, 1);
        // Rate above the range: accepted, carrier stays on
        host.set_rate(32'h0000_61A8);
        host.rd(`QRY_RATE, 32'h0000_61A8);
        repeat (1000) @(posedge ref_clk);
        @(negedge ref_clk);
        seg(1'b1, 2000, n, s);
        chk(n, 2000);
        host.rd(`OFF_STATUS, 32'h0000_0005);
        host.rd(`OFF_RATE_RSVD, 32'h0000_0000);
        // External trigger gates the internal source
        host.wr(`OFF_EXT_TRIG, 32'h1);
        host.rd(`QRY_MODE, `TRIG_EXT);
        repeat (8) @(negedge ref_clk);
        chk({31'h0, rf_gate}, 32'h0);
        trig_pulse(s, n);
        chk(int'(n > 4), 1);
        chk({31'h0, rf_gate}, 32'h0);
        // Amplifier mode: trigger starts conversions only when enabled
        host.wr(`OFF_EXT_TRIG, 32'h0);
        host.wr(`OFF_SRC_SEL, 32'h1);
        host.wr(`OFF_AMP_TRIG, 32'h1);
        repeat (4) @(negedge ref_clk);
        chk({31'h0, src_ext_sel}, 32'h1);
        chk({31'h0, rf_gate}, 32'h0);
        trig_pulse(s, n);
        chk(s, 1);
        chk(n, 0);
        host.wr(`OFF_AMP_TRIG, 32'h0);
        trig_pulse(s, n);
        chk(s, 0);
        host.wr(`OFF_SRC_SEL, 32'h0);
        repeat (4) @(negedge ref_clk);
        chk({31'h0, src_ext_sel}, 32'h0);
        test_done();
    end
endmodule

`default_nettype wire
